/* shared/adc_mode_pkg.sv */
// Constants, codes and carriers of the converter mode and calibration block
package adc_mode_pkg;

    // ------------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] PRI_CTRL_ADDR = 8'hd2;
    localparam logic [7:0] MODE_ADDR = 8'hd1;
    localparam logic [7:0] STATUS_ADDR = 8'hd8;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'hd3;
    localparam logic [7:0] AUX_CFG1_ADDR = 8'hd4;
    localparam logic [7:0] AUX_CFG2_ADDR = 8'hd5;

    // ------------------------------------------------------------------
    // Reset values and implemented-bit mask
    // ------------------------------------------------------------------
    localparam logic [7:0] PRI_CTRL_RESET = 8'h07;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] PRI_CTRL_IMPL_MASK = 8'he7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int CHOP_OFF_BIT = 3;
    localparam int AUX_EN_BIT = 4;
    localparam int PRI_EN_BIT = 5;
    localparam int PRIMARY_READY_FLAG_BIT = 7;
    localparam int AUX_READY_FLAG_BIT = 6;
    localparam int CAL_BUSY_BIT = 5;
    localparam int AUX_ERROR_FLAG_BIT = 4;
    localparam int BUF_LSB = 6;
    localparam int UNI_BIT = 5;
    localparam int RANGE_LSB = 0;

    // ------------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------------
    localparam int CAL_PERIODS_CHOP = 2;
    localparam int CAL_PERIODS_NOCHOP = 4;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_PD = 3'b000,
        MODE_IDLE = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_CONT = 3'b011,
        MODE_CAL_IZ = 3'b100,
        MODE_CAL_IF = 3'b101,
        MODE_CAL_SZ = 3'b110,
        MODE_CAL_SF = 3'b111
    } mode_code_type;

    localparam logic [1:0] BUF_BOTH = 2'b00;
    localparam logic [1:0] BUF_BYPASS = 2'b10;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        logic pri_restart;
        logic aux_restart;
        logic pri_run;
        logic aux_run;
        logic mod_power;
        logic input_short;
        logic ref_to_input;
        logic cal_store_pri;
        logic cal_store_aux;
        logic latch_pri;
        logic latch_aux;
    } fe_ctrl_type;

    typedef struct packed {
        logic buf_bypass;
        logic unipolar;
        logic [2:0] range;
    } analog_cfg_type;

endpackage : adc_mode_pkg

/* design/sync_agree.sv */
// Three-stage synchroniser whose output moves once stages two and three agree
module sync_agree
    import adc_mode_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [SYNC_STAGES-1:0] stage_r;
    logic level_r;
    wire agree = stage_r[1] == stage_r[2];

    // Stage one feeds stage two only; agreement filters one-cycle glitches
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage_r <= '0;
            level_r <= 1'b0;
        end
        else
        begin
            stage_r <= {stage_r[SYNC_STAGES-2:0], i_async};
            if (agree)
                level_r <= stage_r[2];
        end
    end

    assign o_level = level_r;

endmodule : sync_agree

/* design/adc_mode_calibration_control.sv */
// Mode, calibration and primary control sequencer of the converter pair
//
// Contract
// - Mode field selects off, idle, single, continuous
// - Single conversion latches results, flags, returns off
// - Code 100 shorts enabled inputs for calibration
// - Code 101 routes selected reference to inputs
// - Codes 110/111 calibrate on selected channel input
// - Changing mode field resets both converters
// - Rewriting same mode also resets both, unless it only raises aux enable
// - Aux config write with primary enabled, or primary enable rise, resets both
// - Aux control write resets only auxiliary converter
// - Aux restart aligns to primary output cadence
// - Aux starts at once if primary finished
// - Core power-down keeps mode, restarts on return
// - Calibration code clears ready flags, then calibrates
// - Calibration end stores coefficients, flags, mode off
// - Aux calibration on temperature sensor flags error
// - Calibration lasts two or four output periods
// - Bits 7:6 select buffered or bypassed inputs
// - Bit 5 selects unipolar or bipolar coding
// - Bits 2:0 select eight doubling input ranges
// - Bits 4:3 unimplemented, writes ignored
// - Control register at D2H, resets to 07H
module adc_mode_calibration_control
    import adc_mode_pkg::*;
#(
    parameter int CAL_CHOP = CAL_PERIODS_CHOP,
    parameter int CAL_NOCHOP = CAL_PERIODS_NOCHOP
)
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire sfr_req_type I_SFR,
    output logic [7:0] O_SFR_RDATA,
    input wire logic I_CORE_PD,
    input wire logic I_PRI_OUT_STROBE,
    input wire logic I_AUX_OUT_STROBE,
    input wire logic I_AUX_TEMP_SEL,
    output fe_ctrl_type O_FE,
    output analog_cfg_type O_PRI_CFG
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CAL_CHOP < 1 || CAL_CHOP > 7 || CAL_NOCHOP < 1 || CAL_NOCHOP > 7)
    begin : g_bad_cal
        $error("calibration period counts must lie in 1..7");
    end

    localparam logic [2:0] CAL_CHOP_CNT = CAL_CHOP[2:0];
    localparam logic [2:0] CAL_NOCHOP_CNT = CAL_NOCHOP[2:0];

    typedef enum logic [1:0]
    {
        AUX_OFF = 2'b00,
        AUX_ALIGN = 2'b01,
        AUX_RUN = 2'b10
    } aux_state_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] pri_ctrl_r;
    logic [2:0] mode_r;
    logic pri_en_r;
    logic aux_en_r;
    logic chop_off_r;
    logic primary_ready_flag_r;
    logic aux_ready_flag_r;
    logic aux_error_flag_r;
    logic pri_done_r;
    logic aux_done_r;
    logic [2:0] cal_cnt_r;
    logic pd_q_r;
    logic [7:0] rdata_r;
    aux_state_type aux_r;
    aux_state_type aux_nxt;
    fe_ctrl_type fe_r;
    fe_ctrl_type fe_nxt;
    analog_cfg_type cfg_r;
    logic pd_s;

    sync_agree u_pd_sync
    (
        .i_clock(I_CLOCK),
        .i_rst(I_RST),
        .i_async(I_CORE_PD),
        .o_level(pd_s)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_pri_ctrl = I_SFR.wr && I_SFR.addr == PRI_CTRL_ADDR;
    wire wr_mode = I_SFR.wr && I_SFR.addr == MODE_ADDR;
    wire wr_status = I_SFR.wr && I_SFR.addr == STATUS_ADDR;
    wire wr_aux_ctl = I_SFR.wr && I_SFR.addr == AUX_CTRL_ADDR;
    wire wr_aux_cfg = I_SFR.wr
        && (I_SFR.addr == AUX_CFG1_ADDR || I_SFR.addr == AUX_CFG2_ADDR);
    wire [2:0] wmode = I_SFR.wdata[MODE_LSB +: 3];
    wire wpri_en = I_SFR.wdata[PRI_EN_BIT];
    wire waux_en = I_SFR.wdata[AUX_EN_BIT];

    // A rewrite that leaves mode and primary alone but raises the aux
    // enable only disturbs the auxiliary converter
    wire aux_only_mode_wr = wr_mode && wmode == mode_r
        && wpri_en == pri_en_r && waux_en && !aux_en_r;
    wire both_rst = (wr_mode && !aux_only_mode_wr)
        || (wr_aux_cfg && pri_en_r);
    wire aux_rst = aux_only_mode_wr || wr_aux_ctl
        || (wr_aux_cfg && !pri_en_r);
    wire pd_fall = pd_q_r && !pd_s;
    wire cal_start = wr_mode && wmode[2];

    // ------------------------------------------------------------------
    // Sequencing terms
    // ------------------------------------------------------------------
    wire active = !pd_s && mode_r != MODE_PD;
    wire converting = active && mode_r != MODE_IDLE;
    wire in_single = mode_r == MODE_SINGLE;
    wire in_cont = mode_r == MODE_CONT;
    wire in_cal = mode_r[2];
    wire pri_live = fe_r.pri_run && !fe_r.pri_restart;
    wire aux_live = aux_r == AUX_RUN && fe_r.aux_run && !fe_r.aux_restart;
    wire pri_tick = I_PRI_OUT_STROBE && pri_live;
    wire aux_tick = I_AUX_OUT_STROBE && aux_live;
    wire pri_busy = pri_live && (in_cont || in_cal
        || (in_single && !pri_done_r));
    wire [2:0] cal_target = chop_off_r ? CAL_NOCHOP_CNT : CAL_CHOP_CNT;
    wire lead_tick = pri_en_r ? pri_tick : aux_tick;
    wire cal_done = converting && in_cal && !both_rst
        && ((!pri_en_r && !aux_en_r)
        || (lead_tick && cal_cnt_r == cal_target - 3'd1));
    wire single_done = converting && in_single && !both_rst
        && (pri_done_r || !pri_en_r) && (aux_done_r || !aux_en_r);
    wire aux_cal_bad = aux_en_r && I_AUX_TEMP_SEL;
    wire conv_latch_pri = pri_tick && (in_single || in_cont) && pri_en_r;
    wire conv_latch_aux = aux_tick && (in_single || in_cont) && aux_en_r;
    wire set_primary_ready_flag = conv_latch_pri || (cal_done && pri_en_r);
    wire set_aux_ready_flag = conv_latch_aux || (cal_done && aux_en_r);
    wire clr_primary_ready_flag = (wr_status && I_SFR.wdata[PRIMARY_READY_FLAG_BIT]) || cal_start;
    wire clr_aux_ready_flag = (wr_status && I_SFR.wdata[AUX_READY_FLAG_BIT]) || cal_start;
    wire clr_aux_error_flag = (wr_status && I_SFR.wdata[AUX_ERROR_FLAG_BIT]) || cal_start;

    // Hardware return to off loses to a software mode write
    wire [2:0] mode_nxt = wr_mode ? wmode
        : (cal_done || single_done) ? MODE_PD
        : mode_r;

    // ------------------------------------------------------------------
    // Auxiliary alignment
    // ------------------------------------------------------------------
    // Joining mid-stream would leave the aux phase-shifted from primary
    always_comb
    begin
        aux_nxt = aux_r;
        if (both_rst || pd_fall)
            aux_nxt = AUX_RUN;
        else if (aux_rst)
            aux_nxt = pri_busy ? AUX_ALIGN : AUX_RUN;
        else
        begin
            case (aux_r)
                AUX_OFF:
                    aux_nxt = (converting && aux_en_r) ? AUX_RUN : AUX_OFF;
                AUX_ALIGN:
                    if (!(converting && aux_en_r))
                        aux_nxt = AUX_OFF;
                    else if (I_PRI_OUT_STROBE || !pri_busy)
                        aux_nxt = AUX_RUN;
                AUX_RUN:
                    aux_nxt = (converting && aux_en_r) ? AUX_RUN : AUX_OFF;
                default:
                    aux_nxt = AUX_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Front-end controls
    // ------------------------------------------------------------------
    wire aux_release = aux_r == AUX_ALIGN && aux_nxt == AUX_RUN;
    wire [2:0] nm = mode_nxt;
    wire nm_conv = !pd_s && nm != MODE_PD && nm != MODE_IDLE;
    wire npri_en = wr_mode ? wpri_en : pri_en_r;
    wire naux_en = wr_mode ? waux_en : aux_en_r;

    always_comb
    begin
        fe_nxt = '0;
        fe_nxt.pri_restart = both_rst || pd_fall;
        fe_nxt.aux_restart = both_rst || aux_rst || pd_fall || aux_release;
        fe_nxt.pri_run = nm_conv && npri_en;
        fe_nxt.aux_run = nm_conv && naux_en && aux_nxt == AUX_RUN;
        fe_nxt.mod_power = !pd_s && nm != MODE_PD;
        fe_nxt.input_short = nm_conv && nm == MODE_CAL_IZ;
        fe_nxt.ref_to_input = nm_conv && nm == MODE_CAL_IF;
        fe_nxt.cal_store_pri = cal_done && pri_en_r;
        fe_nxt.cal_store_aux = cal_done && aux_en_r && !I_AUX_TEMP_SEL;
        fe_nxt.latch_pri = conv_latch_pri;
        fe_nxt.latch_aux = conv_latch_aux;
    end
    // System calibrations simply keep the selected channels connected

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [7:0] mode_view = {2'b00, pri_en_r, aux_en_r, chop_off_r, mode_r};
    wire [7:0] stat_view = {primary_ready_flag_r, aux_ready_flag_r, in_cal && active, aux_error_flag_r, 4'h0};
    wire [7:0] rdata_nxt = (I_SFR.addr == PRI_CTRL_ADDR)
        ? (pri_ctrl_r & PRI_CTRL_IMPL_MASK)
        : (I_SFR.addr == MODE_ADDR) ? mode_view
        : (I_SFR.addr == STATUS_ADDR) ? stat_view
        : 8'h00;

    // ------------------------------------------------------------------
    // Primary control register and its decoded fields
    // ------------------------------------------------------------------
    wire [1:0] buf_field = pri_ctrl_r[BUF_LSB +: 2];
    wire [7:0] pri_ctrl_nxt = wr_pri_ctrl ? I_SFR.wdata : pri_ctrl_r;
    wire analog_cfg_type cfg_nxt = '{
        buf_bypass: buf_field == BUF_BYPASS,
        unipolar: pri_ctrl_r[UNI_BIT],
        range: pri_ctrl_r[RANGE_LSB +: 3]
    };

    // Configuration storage
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pri_ctrl_r <= PRI_CTRL_RESET;
            mode_r <= MODE_RESET[2:0];
            pri_en_r <= 1'b0;
            aux_en_r <= 1'b0;
            chop_off_r <= 1'b0;
            cfg_r <= '{PRI_CTRL_RESET[BUF_LSB +: 2] == BUF_BYPASS,
                PRI_CTRL_RESET[UNI_BIT], PRI_CTRL_RESET[RANGE_LSB +: 3]};
        end
        else
        begin
            pri_ctrl_r <= pri_ctrl_nxt;
            mode_r <= mode_nxt;
            if (wr_mode)
            begin
                pri_en_r <= wpri_en;
                aux_en_r <= waux_en;
                chop_off_r <= I_SFR.wdata[CHOP_OFF_BIT];
            end
            cfg_r <= cfg_nxt;
        end
    end

    // Status flags: a set in the cycle of a clear wins
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            primary_ready_flag_r <= 1'b0;
            aux_ready_flag_r <= 1'b0;
            aux_error_flag_r <= 1'b0;
        end
        else
        begin
            primary_ready_flag_r <= set_primary_ready_flag || (primary_ready_flag_r && !clr_primary_ready_flag);
            aux_ready_flag_r <= set_aux_ready_flag || (aux_ready_flag_r && !clr_aux_ready_flag);
            aux_error_flag_r <= (cal_done && aux_cal_bad) || (aux_error_flag_r && !clr_aux_error_flag);
        end
    end

    // Progress of the current operation
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pri_done_r <= 1'b0;
            aux_done_r <= 1'b0;
            cal_cnt_r <= 3'd0;
            pd_q_r <= 1'b0;
            aux_r <= AUX_OFF;
        end
        else
        begin
            pd_q_r <= pd_s;
            aux_r <= aux_nxt;
            if (both_rst || pd_fall || cal_done || single_done)
            begin
                pri_done_r <= 1'b0;
                aux_done_r <= 1'b0;
                cal_cnt_r <= 3'd0;
            end
            else
            begin
                pri_done_r <= pri_done_r || conv_latch_pri;
                aux_done_r <= (aux_done_r && !aux_rst) || conv_latch_aux;
                if (in_cal && lead_tick)
                    cal_cnt_r <= cal_cnt_r + 3'd1;
            end
        end
    end

    // Outputs and read data
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            fe_r <= '0;
            rdata_r <= 8'h00;
        end
        else
        begin
            fe_r <= fe_nxt;
            if (I_SFR.rd)
                rdata_r <= rdata_nxt;
        end
    end

    assign O_FE = fe_r;
    assign O_PRI_CFG = cfg_r;
    assign O_SFR_RDATA = rdata_r;

endmodule : adc_mode_calibration_control

/* bench/adc_mode_checker.sv */
// Port checker of the converter mode and calibration sequencer
module adc_mode_checker
    import adc_mode_pkg::*;
#(
    parameter int CAL_CHOP = CAL_PERIODS_CHOP,
    parameter int CAL_NOCHOP = CAL_PERIODS_NOCHOP
)
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire sfr_req_type I_SFR,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic I_CORE_PD,
    input wire logic I_PRI_OUT_STROBE,
    input wire logic I_AUX_OUT_STROBE,
    input wire logic I_AUX_TEMP_SEL,
    input wire fe_ctrl_type O_FE,
    input wire analog_cfg_type O_PRI_CFG
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    // Write decodes seen on the register bus
    wire mode_wr = I_SFR.wr && (I_SFR.addr == MODE_ADDR);
    wire ctrl_wr = I_SFR.wr && (I_SFR.addr == PRI_CTRL_ADDR);
    wire aux_wr = I_SFR.wr && (I_SFR.addr == AUX_CTRL_ADDR);
    wire cfg_wr = I_SFR.wr && ((I_SFR.addr == AUX_CFG1_ADDR)
        || (I_SFR.addr == AUX_CFG2_ADDR));
    logic pri_en_r;
    analog_cfg_type cfg_exp_r;

    // Shadow of primary enable and expected analog settings
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pri_en_r <= 1'b0;
            cfg_exp_r <= '{1'b0, 1'b0, 3'h7};
        end
        else
        begin
            if (mode_wr)
                pri_en_r <= I_SFR.wdata[PRI_EN_BIT];
            if (ctrl_wr)
                cfg_exp_r <= '{(I_SFR.wdata[7:6] == BUF_BYPASS),
                    I_SFR.wdata[UNI_BIT], I_SFR.wdata[2:0]};
        end
    end

    // A mode write without the aux enable can never be the aux-only case
    sequence s_mode_wr;
        mode_wr && !I_SFR.wdata[AUX_EN_BIT];
    endsequence
    sequence s_both_restart;
        O_FE.pri_restart && O_FE.aux_restart;
    endsequence
    sequence s_pd_held;
        I_CORE_PD [*7];
    endsequence

    a_mode_resets_both: assert property (s_mode_wr |=> s_both_restart)
        else $error("mode write did not restart both converters");
    a_cfg_resets_both: assert property (cfg_wr && pri_en_r |=> s_both_restart)
        else $error("aux config write did not restart both");
    a_aux_ctrl_only: assert property (aux_wr |=> !O_FE.pri_restart)
        else $error("aux control write restarted primary");
    a_aux_align_bound: assert property (aux_wr && O_FE.pri_run
        && !O_FE.pri_restart && !O_FE.latch_pri
        |=> ##[1:400] (O_FE.aux_restart && $past(I_PRI_OUT_STROBE)))
        else $error("aux restart did not follow a primary tick");
    a_ctrl_cfg_follow: assert property (ctrl_wr |-> ##2 (O_PRI_CFG == $past(cfg_exp_r)))
        else $error("analog settings do not follow control write");
    a_latch_after_tick: assert property (O_FE.latch_pri |-> $past(I_PRI_OUT_STROBE))
        else $error("primary latch without output tick");
    a_aux_latch_tick: assert property (O_FE.latch_aux |-> $past(I_AUX_OUT_STROBE))
        else $error("aux latch without output tick");
    a_cal_route_excl: assert property (!(O_FE.input_short && O_FE.ref_to_input))
        else $error("short and reference routed together");
    a_temp_no_store: assert property (O_FE.cal_store_pri && I_AUX_TEMP_SEL |-> !O_FE.cal_store_aux)
        else $error("aux coefficients stored with sensor selected");
    a_pd_quiet: assert property (s_pd_held |-> !O_FE.mod_power && !O_FE.pri_run && !O_FE.aux_run)
        else $error("converters active during core power-down");
endmodule : adc_mode_checker

bind adc_mode_calibration_control adc_mode_checker #(.CAL_CHOP(CAL_CHOP),
    .CAL_NOCHOP(CAL_NOCHOP)) chk_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
    .I_SFR(I_SFR), .O_SFR_RDATA(O_SFR_RDATA), .I_CORE_PD(I_CORE_PD),
    .I_PRI_OUT_STROBE(I_PRI_OUT_STROBE), .I_AUX_OUT_STROBE(I_AUX_OUT_STROBE),
    .I_AUX_TEMP_SEL(I_AUX_TEMP_SEL), .O_FE(O_FE), .O_PRI_CFG(O_PRI_CFG));

/* bench/afe_model.sv */
// Behavioural analog front end: output ticks of both filters
module afe_model
    import adc_mode_pkg::*;
(
    input wire logic i_clock,
    input wire fe_ctrl_type i_fe,
    input wire logic [7:0] i_period,
    output logic o_pri_strobe,
    output logic o_aux_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    int pri_cnt = 0;
    int aux_cnt = 0;

    initial
    begin
        o_pri_strobe = 1'b0;
        o_aux_strobe = 1'b0;
    end

    // A filter ticks only while running; a restart begins a fresh period
    always @(posedge i_clock)
    begin
        o_pri_strobe <= 1'b0;
        o_aux_strobe <= 1'b0;
        pri_cnt <= pri_cnt + 1;
        aux_cnt <= aux_cnt + 1;
        if (i_fe.pri_restart || !i_fe.pri_run)
            pri_cnt <= 0;
        else if (pri_cnt >= i_period - 1)
        begin
            pri_cnt <= 0;
            o_pri_strobe <= 1'b1;
        end
        if (i_fe.aux_restart || !i_fe.aux_run)
            aux_cnt <= 0;
        else if (aux_cnt >= i_period - 1)
        begin
            aux_cnt <= 0;
            o_aux_strobe <= 1'b1;
        end
    end
endmodule : afe_model

/* bench/adc_mode_calibration_control_bench.sv */
// Self-checking bench of the converter mode and calibration sequencer
module adc_mode_calibration_control_bench
    import adc_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 1;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    sfr_req_type sfr = '0;
    logic [7:0] rdata;
    logic core_pd = 1'b0;
    logic pri_stb;
    logic aux_stb;
    logic temp_sel = 1'b0;
    fe_ctrl_type fe;
    analog_cfg_type cfg;
    logic [7:0] period = 8'h14;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int pcount = 0;
    int plast = 0;
    int ctrl_m = 8'h07;
    logic aux_store_seen = 1'b0;
    logic rst_p;
    logic rst_a;
    logic [7:0] rd_v;

    adc_mode_calibration_control #(.CAL_CHOP(CAL_PERIODS_CHOP),
        .CAL_NOCHOP(CAL_PERIODS_NOCHOP)) dut_u (.I_CLOCK(clock), .I_RST(rst),
        .I_SFR(sfr), .O_SFR_RDATA(rdata), .I_CORE_PD(core_pd),
        .I_PRI_OUT_STROBE(pri_stb), .I_AUX_OUT_STROBE(aux_stb),
        .I_AUX_TEMP_SEL(temp_sel), .O_FE(fe), .O_PRI_CFG(cfg));
    afe_model afe_u (.i_clock(clock), .i_fe(fe), .i_period(period),
        .o_pri_strobe(pri_stb), .o_aux_strobe(aux_stb));

    always #50 clock = ~clock;

    // Tick counting, store watch and hang limit
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (pri_stb)
        begin
            pcount <= pcount + 1;
            plast <= cyc;
        end
        if (fe.cal_store_aux)
            aux_store_seen <= 1'b1;
        if (cyc == LIMIT)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    // Analog settings that a control byte should give
    function automatic analog_cfg_type exp_cfg(input int c);
        return '{(c[7:6] == 2'b10), c[5], c[2:0]};
    endfunction : exp_cfg

    task automatic chk_byte(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit

    task automatic step();
        @(posedge clock);
        #DLY;
    endtask : step

    // Write strobe for one cycle; restart pulses are seen right after
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        step();
        sfr = '{1'b1, 1'b0, a, d};
        step();
        sfr.wr = 1'b0;
        rst_p = fe.pri_restart;
        rst_a = fe.aux_restart;
    endtask : sfr_write

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
        input string what);
        step();
        sfr = '{1'b0, 1'b1, a, 8'h00};
        step();
        sfr.rd = 1'b0;
        rd_v = rdata;
        chk_byte(what, exp, rd_v);
    endtask : rd_chk

    // The aux restart must land just after a primary output tick; the
    // immediate aux-only restart pulse of the write is skipped first
    task automatic wait_aux();
        int i;
        step();
        for (i = 0; i < 400 && fe.aux_restart !== 1'b1; i++)
            step();
        chk_bit("aux_restart", 1'b1, fe.aux_restart);
        chk_bit("aux_aligned", 1'b1, (cyc - plast) <= 3);
    endtask : wait_aux

    task automatic wait_store();
        int i;
        for (i = 0; i < 1000 && fe.cal_store_pri !== 1'b1; i++)
            step();
        chk_bit("cal_store_pri", 1'b1, fe.cal_store_pri);
    endtask : wait_store

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial
    begin
        int i;
        int c;
        int code;
        int chop;
        int snap;
        logic [7:0] w;
        void'($urandom(57));
        repeat (20) @(posedge clock);
        #DLY;
        rst = 1'b0;
        rd_chk(PRI_CTRL_ADDR, 8'h07, "ctrl_reset");
        chk_byte("cfg_reset", 8'h07, {3'h0, cfg});
        rd_chk(MODE_ADDR, 8'h00, "mode_reset");
        sfr_write(8'he0, 8'h5a);
        rd_chk(8'he0, 8'h00, "unmapped");
        for (i = 0; i < 8; i++)
        begin
            w = 8'($urandom());
            w[2:0] = 3'(i);
            w[7:6] = 2'(i);
            ctrl_m = w & 8'he7;
            sfr_write(PRI_CTRL_ADDR, w);
            rd_chk(PRI_CTRL_ADDR, 8'(ctrl_m), "ctrl");
            chk_byte("cfg", {3'h0, exp_cfg(ctrl_m)}, {3'h0, cfg});
        end
        sfr_write(MODE_ADDR, 8'h22);
        chk_bit("single_restart", 1'b1, rst_p & rst_a);
        for (i = 0; i < 400 && fe.latch_pri !== 1'b1; i++)
            step();
        chk_bit("latch_pri", 1'b1, fe.latch_pri);
        repeat (3) step();
        rd_chk(MODE_ADDR, 8'h20, "single_mode_off");
        rd_chk(STATUS_ADDR, 8'h80, "single_status");
        sfr_write(STATUS_ADDR, 8'hd0);
        sfr_write(MODE_ADDR, 8'h23);
        sfr_write(MODE_ADDR, 8'h23);
        chk_bit("same_mode_restart", 1'b1, rst_p & rst_a);
        chk_bit("cont_run", 1'b1, fe.pri_run);
        sfr_write(MODE_ADDR, 8'h33);
        chk_bit("aux_en_pri_kept", 1'b0, rst_p);
        wait_aux();
        sfr_write(AUX_CTRL_ADDR, 8'($urandom()));
        chk_bit("aux_ctrl_pri_kept", 1'b0, rst_p);
        wait_aux();
        chk_bit("pri_undisturbed", 1'b1, fe.pri_run);
        sfr_write(AUX_CFG1_ADDR, 8'($urandom()));
        chk_bit("cfg_both_restart", 1'b1, rst_p & rst_a);
        core_pd = 1'b1;
        repeat (8) step();
        chk_bit("pd_power", 1'b0, fe.mod_power);
        rd_chk(MODE_ADDR, 8'h33, "pd_mode_kept");
        core_pd = 1'b0;
        for (i = 0; i < 12 && fe.pri_restart !== 1'b1; i++)
            step();
        chk_bit("pd_resume", 1'b1, fe.pri_restart);
        sfr_write(MODE_ADDR, 8'h21);
        chk_bit("idle_run", 1'b0, fe.pri_run);
        chk_bit("idle_power", 1'b1, fe.mod_power);
        period = 8'h28;
        for (c = 0; c < 8; c++)
        begin
            code = 4 + c % 4;
            chop = c / 4;
            w = 8'(8'h20 | (chop << CHOP_OFF_BIT) | code);
            sfr_write(MODE_ADDR, w);
            rd_chk(STATUS_ADDR, 8'h20, "rdy_cleared");
            snap = pcount;
            chk_bit("short", code == 4, fe.input_short);
            chk_bit("ref_route", code == 5, fe.ref_to_input);
            wait_store();
            chk_byte("cal_periods", 8'(chop ? CAL_PERIODS_NOCHOP
                : CAL_PERIODS_CHOP), 8'(pcount - snap));
            repeat (3) step();
            rd_chk(MODE_ADDR, w & 8'hf8, "cal_mode_off");
            rd_chk(STATUS_ADDR, 8'h80, "cal_status");
        end
        temp_sel = 1'b1;
        aux_store_seen = 1'b0;
        sfr_write(MODE_ADDR, 8'h34);
        wait_store();
        repeat (3) step();
        rd_chk(STATUS_ADDR, 8'hd0, "temp_cal_status");
        chk_bit("temp_no_aux_store", 1'b0, aux_store_seen);
        temp_sel = 1'b0;
        tally_and_finish();
    end
endmodule : adc_mode_calibration_control_bench
